// >>> design/bopd_decoder.sv
// Byte-op instruction decoder with APB control and status registers.
// Assumes one fetched word per valid cycle and a datapath that reports skip tests.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module bopd_decoder #(
	parameter int APB_AW = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Fetch path
	input wire logic [15:0] fetchWord,
	input wire logic fetchValid,
	// Datapath feedback: test of the shown conditional instruction is true
	input wire logic testTrue,
	// Decoded controls
	output bopd_pkg::bopd_op_type opCode,
	output logic opValid,
	output logic execNop,
	output logic accWrite,
	output logic regWrite,
	output logic [11:0] regAddr,
	output logic [2:0] bitPos,
	output logic [7:0] literal,
	output logic [4:0] flagMask,
	output logic condOp,
	output logic pcChange,
	output logic [10:0] longOffset,
	output logic [7:0] shortOffset,
	output logic [11:0] moveSrc,
	output logic [11:0] moveDst,
	output logic moveValid,
	output logic [19:0] target,
	output logic targetValid,
	output logic shadowSave,
	output logic productWrite,
	output logic readPins,
	output logic prescalerClear
);
	typedef enum {ST_FIRST, ST_SECOND, ST_FLUSH} bopd_state_type;

	bopd_fields_if fld ();
	bopd_state_type state;
	bopd_state_type next_state;
	logic [bopd_pkg::BANK_W-1:0] bankSel;
	logic prescAssigned;
	logic [11:0] timerAddr;
	logic [11:0] portLo;
	logic [11:0] portHi;
	logic [31:0] decodeCount;
	logic pendCall;
	logic pendFast;
	logic [11:0] pendSrc;
	logic [7:0] pendLow;
	bopd_pkg::bopd_op_type next_op;
	logic [4:0] next_flags;
	logic next_hasDest;
	logic next_writesReg;
	logic next_cond;
	logic next_pc;
	logic next_nop;
	logic next_twoWord;
	logic next_second;
	logic [11:0] next_addr;
	logic rmwOp;
	logic apbAccess;

	assign fld.word = fetchWord;

	bopd_field_split u_split (
		.fld(fld)
	);

	//////////////////////////////////////////////////////////////////////////////
	// Operation decode

	// Opcode table of the byte-oriented group
	always_comb begin
		next_op = bopd_pkg::OP_OTHER;
		next_flags = bopd_pkg::FLAGS_NONE;
		next_hasDest = 1'b1;
		next_writesReg = 1'b1;
		next_cond = 1'b0;
		next_pc = 1'b0;
		case (fld.prefix)
			bopd_pkg::PFX_MISC: begin
				if (fld.sub2 == bopd_pkg::SUB2_1) begin
					next_op = bopd_pkg::OP_DEC;
					next_flags = bopd_pkg::FLAGS_ALL;
				end else if (fld.sub3 == bopd_pkg::SUB3_MUL) begin
					next_op = bopd_pkg::OP_MUL;
					next_hasDest = 1'b0;
					next_writesReg = 1'b0;
				end else begin
					// Control and literal words here touch no file register
					next_writesReg = 1'b0;
				end
			end
			bopd_pkg::PFX_LOGIC: begin
				next_flags = bopd_pkg::FLAGS_ZN;
				case (fld.sub2)
					bopd_pkg::SUB2_0: next_op = bopd_pkg::OP_OR;
					bopd_pkg::SUB2_1: next_op = bopd_pkg::OP_AND;
					bopd_pkg::SUB2_2: next_op = bopd_pkg::OP_XOR;
					default: next_op = bopd_pkg::OP_COMP;
				endcase
			end
			bopd_pkg::PFX_ADD: begin
				case (fld.sub2)
					bopd_pkg::SUB2_0: begin
						next_op = bopd_pkg::OP_ADDC;
						next_flags = bopd_pkg::FLAGS_ALL;
					end
					bopd_pkg::SUB2_1: begin
						next_op = bopd_pkg::OP_ADD;
						next_flags = bopd_pkg::FLAGS_ALL;
					end
					bopd_pkg::SUB2_2: begin
						next_op = bopd_pkg::OP_INC;
						next_flags = bopd_pkg::FLAGS_ALL;
					end
					default: begin
						next_op = bopd_pkg::OP_DEC_SZ;
						next_cond = 1'b1;
					end
				endcase
			end
			bopd_pkg::PFX_ROT: begin
				case (fld.sub2)
					bopd_pkg::SUB2_0: begin
						next_op = bopd_pkg::OP_RR_C;
						next_flags = bopd_pkg::FLAGS_CZN;
					end
					bopd_pkg::SUB2_1: begin
						next_op = bopd_pkg::OP_RL_C;
						next_flags = bopd_pkg::FLAGS_CZN;
					end
					bopd_pkg::SUB2_2: next_op = bopd_pkg::OP_SWAP;
					default: begin
						next_op = bopd_pkg::OP_INC_SZ;
						next_cond = 1'b1;
					end
				endcase
			end
			bopd_pkg::PFX_DSKIP: begin
				case (fld.sub2)
					bopd_pkg::SUB2_0: begin
						next_op = bopd_pkg::OP_RR_PLAIN;
						next_flags = bopd_pkg::FLAGS_ZN;
					end
					bopd_pkg::SUB2_1: begin
						next_op = bopd_pkg::OP_RL_PLAIN;
						next_flags = bopd_pkg::FLAGS_ZN;
					end
					bopd_pkg::SUB2_2: begin
						next_op = bopd_pkg::OP_INC_SNZ;
						next_cond = 1'b1;
					end
					default: begin
						next_op = bopd_pkg::OP_DEC_SNZ;
						next_cond = 1'b1;
					end
				endcase
			end
			bopd_pkg::PFX_SUB: begin
				next_flags = bopd_pkg::FLAGS_ALL;
				case (fld.sub2)
					bopd_pkg::SUB2_0: begin
						next_op = bopd_pkg::OP_REG_MOVE;
						next_flags = bopd_pkg::FLAGS_ZN;
					end
					bopd_pkg::SUB2_1: next_op = bopd_pkg::OP_RSUB_B;
					bopd_pkg::SUB2_2: next_op = bopd_pkg::OP_SUB_B;
					default: next_op = bopd_pkg::OP_SUB;
				endcase
			end
			bopd_pkg::PFX_REG: begin
				// No destination bit here: results go to the register
				next_hasDest = 1'b0;
				case (fld.sub3)
					3'h0: next_op = bopd_pkg::OP_CMP_LT;
					3'h1: next_op = bopd_pkg::OP_CMP_EQ;
					3'h2: next_op = bopd_pkg::OP_CMP_GT;
					3'h3: next_op = bopd_pkg::OP_TEST_ZERO;
					3'h4: next_op = bopd_pkg::OP_SET;
					3'h5: begin
						next_op = bopd_pkg::OP_CLEAR;
						next_flags = bopd_pkg::FLAGS_Z;
					end
					3'h6: begin
						next_op = bopd_pkg::OP_NEGATE;
						next_flags = bopd_pkg::FLAGS_ALL;
					end
					default: next_op = bopd_pkg::OP_ACC_MOVE;
				endcase
				if (fld.sub3 <= 3'h3) begin
					next_cond = 1'b1;
					next_writesReg = 1'b0;
				end
			end
			bopd_pkg::PFX_MOVE: begin
				next_op = bopd_pkg::OP_REG_REG_MOVE;
				next_writesReg = 1'b0;
			end
			bopd_pkg::PFX_REL: begin
				next_op = fld.word[bopd_pkg::OP_FIELD_MSB] ? bopd_pkg::OP_REL_CALL
					: bopd_pkg::OP_BRANCH_ALWAYS;
				next_pc = 1'b1;
				next_writesReg = 1'b0;
			end
			bopd_pkg::PFX_CTRL: begin
				next_writesReg = 1'b0;
				if (!fld.word[bopd_pkg::OP_FIELD_MSB]) begin
					next_op = bopd_pkg::OP_COND_BRANCH;
					next_cond = 1'b1;
				end else if (fld.sub3 == bopd_pkg::SUB3_CALL) begin
					next_op = bopd_pkg::OP_CALL;
				end else if (fld.sub4 == bopd_pkg::CTRL_GOTO) begin
					next_op = bopd_pkg::OP_GOTO;
				end
			end
			bopd_pkg::PFX_SECOND: begin
				next_op = bopd_pkg::OP_NOP;
				next_writesReg = 1'b0;
			end
			default: begin
				next_writesReg = 1'b0;
			end
		endcase
	end

	// Word kind and sequencing
	assign next_nop = (state == ST_FLUSH) || (condOp && testTrue);
	assign next_second = (state == ST_SECOND) && fld.secondTag;
	assign next_twoWord = (next_op == bopd_pkg::OP_REG_REG_MOVE) || (next_op == bopd_pkg::OP_CALL)
		|| (next_op == bopd_pkg::OP_GOTO);
	// Bank choice for the file operand
	assign next_addr = fld.accessSel ? {bankSel, fld.fileAddr}
		: {bopd_pkg::ACCESS_BANK, fld.fileAddr};
	// Operations that read the register and write it back
	assign rmwOp = next_hasDest ? fld.destSel
		: (next_op == bopd_pkg::OP_NEGATE);

	// Sequencer
	always_comb begin
		next_state = state;
		if (fetchValid) begin
			if (next_nop) begin
				next_state = ST_FIRST;
			end else if (next_second) begin
				next_state = pendCall ? ST_FLUSH : ST_FIRST;
			end else if (next_twoWord) begin
				next_state = ST_SECOND;
			end else if (next_pc) begin
				next_state = ST_FLUSH;
			end else begin
				next_state = ST_FIRST;
			end
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_FIRST;
		end else begin
			state <= next_state;
		end
	end

	// First-word operands kept for the second word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pendCall <= 1'b0;
			pendFast <= 1'b0;
			pendSrc <= '0;
			pendLow <= '0;
		end else if (fetchValid && !next_nop && !next_second && next_twoWord) begin
			pendCall <= (next_op != bopd_pkg::OP_REG_REG_MOVE);
			pendFast <= (next_op == bopd_pkg::OP_CALL) && fld.fastSel;
			pendSrc <= fld.addr12;
			pendLow <= fld.literal;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Registered decode outputs

	// Operation and effects of the current word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			opCode <= bopd_pkg::OP_NOP;
			opValid <= 1'b0;
			execNop <= 1'b0;
			flagMask <= bopd_pkg::FLAGS_NONE;
			accWrite <= 1'b0;
			regWrite <= 1'b0;
			condOp <= 1'b0;
			pcChange <= 1'b0;
			productWrite <= 1'b0;
			readPins <= 1'b0;
			prescalerClear <= 1'b0;
		end else begin
			opValid <= fetchValid;
			// A lone second word runs as a no-operation too
			execNop <= fetchValid && (next_nop || next_second || fld.secondTag);
			if (!fetchValid || next_nop || next_second) begin
				opCode <= bopd_pkg::OP_NOP;
				flagMask <= bopd_pkg::FLAGS_NONE;
				accWrite <= 1'b0;
				regWrite <= 1'b0;
				condOp <= 1'b0;
				pcChange <= next_second && pendCall && fetchValid;
				productWrite <= 1'b0;
				readPins <= 1'b0;
				prescalerClear <= 1'b0;
			end else begin
				opCode <= next_op;
				flagMask <= next_flags;
				accWrite <= next_hasDest && next_writesReg && !fld.destSel;
				regWrite <= next_writesReg && (!next_hasDest || fld.destSel);
				condOp <= next_cond;
				pcChange <= next_pc;
				productWrite <= (next_op == bopd_pkg::OP_MUL);
				readPins <= next_writesReg && rmwOp && (next_addr >= portLo)
					&& (next_addr <= portHi);
				prescalerClear <= prescAssigned && next_writesReg && (next_addr == timerAddr)
					&& (!next_hasDest || fld.destSel);
			end
		end
	end

	// Operand fields
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regAddr <= '0;
			bitPos <= '0;
			literal <= '0;
			longOffset <= '0;
			shortOffset <= '0;
		end else if (fetchValid) begin
			regAddr <= next_addr;
			bitPos <= fld.bitPos;
			literal <= fld.literal;
			longOffset <= fld.longOff;
			shortOffset <= fld.literal;
		end
	end

	// Two-word completions
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			moveSrc <= '0;
			moveDst <= '0;
			moveValid <= 1'b0;
			target <= '0;
			targetValid <= 1'b0;
			shadowSave <= 1'b0;
		end else begin
			moveValid <= fetchValid && next_second && !pendCall;
			targetValid <= fetchValid && next_second && pendCall;
			shadowSave <= fetchValid && next_second && pendCall && pendFast;
			if (fetchValid && next_second) begin
				moveSrc <= pendSrc;
				moveDst <= fld.addr12;
				target <= {fld.addr12, pendLow};
			end
		end
	end

	// Count of words decoded as real operations
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			decodeCount <= '0;
		end else if (fetchValid && !next_nop && !fld.secondTag) begin
			decodeCount <= decodeCount + 32'h0000_0001;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// APB registers

	assign apbAccess = psel && penable && !pready;

	// Writable registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bankSel <= '0;
			prescAssigned <= 1'b0;
			timerAddr <= bopd_pkg::TIMER_ADDR_RST;
			portLo <= bopd_pkg::PORT_LO_RST;
			portHi <= bopd_pkg::PORT_HI_RST;
		end else if (apbAccess && pwrite) begin
			if (paddr == bopd_pkg::REG_BANK) begin
				bankSel <= pwdata[bopd_pkg::BANK_W-1:0];
			end else if (paddr == bopd_pkg::REG_CTRL) begin
				prescAssigned <= pwdata[bopd_pkg::CTRL_PRESC_BIT];
			end else if (paddr == bopd_pkg::REG_TIMER) begin
				timerAddr <= pwdata[bopd_pkg::ADDR_W-1:0];
			end else if (paddr == bopd_pkg::REG_PORT_LO) begin
				portLo <= pwdata[bopd_pkg::ADDR_W-1:0];
			end else if (paddr == bopd_pkg::REG_PORT_HI) begin
				portHi <= pwdata[bopd_pkg::ADDR_W-1:0];
			end
		end
	end

	// Answer one cycle into the access phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= apbAccess;
			pslverr <= 1'b0;
			prdata <= '0;
			if (apbAccess) begin
				if (paddr == bopd_pkg::REG_BANK) begin
					prdata <= {28'h0000000, bankSel};
				end else if (paddr == bopd_pkg::REG_CTRL) begin
					prdata <= {31'h00000000, prescAssigned};
				end else if (paddr == bopd_pkg::REG_TIMER) begin
					prdata <= {20'h00000, timerAddr};
				end else if (paddr == bopd_pkg::REG_PORT_LO) begin
					prdata <= {20'h00000, portLo};
				end else if (paddr == bopd_pkg::REG_PORT_HI) begin
					prdata <= {20'h00000, portHi};
				end else if (paddr == bopd_pkg::REG_STATUS) begin
					prdata <= {22'h000000, state == ST_FLUSH, state == ST_SECOND,
						2'h0, opCode};
				end else if (paddr == bopd_pkg::REG_COUNT) begin
					prdata <= decodeCount;
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end
endmodule // bopd_decoder

// >>> inc/bopd_pkg.sv
// Constants, field positions and types of the byte-op instruction decoder.
// Assumes a 16-bit program word per fetch and an APB master with 32-bit data.
//
// Notes on behaviour
// - Each instruction is decoded from a 16-bit word, opcode on top, operands below.
// - Destination bit 0 sends result to accumulator, 1 back to the file register.
// - Access bit 0 forces the access bank; 1 takes bank from bank select.
// - Byte and bit operations take their register from the low 8-bit field.
// - Two-word move: 12-bit source in word one (1100), destination in word two (1111).
// - Bit operations pick the target bit by a 3-bit position field.
// - Literal operations take an 8-bit immediate from the low byte.
// - Call and jump build a 20-bit target: low byte first, high twelve from 1111 word.
// - The call format carries a fast bit choosing fast call and return.
// - Unconditional relative branch uses 11-bit offset; conditional ones 8-bit low byte.
// - A second word runs as no-operation, whether alone or consumed by its first word.
// - Program-counter change or true skip costs two cycles, second a no-operation.
// - Read-modify-write of a port register reads pins, not the output latch.
// - Writing the timer zero count clears the prescaler when it is assigned there.
// - Add 0010 01da, add with carry 0010 00da: one cycle, all five flags.
// - Prefix 0001: or 00da, and 01da, xor 10da, complement 11da; zero, negative.
// - Prefix 0110: skip less 000a, equal 001a, greater 010a, zero test 011a; no flags.
// - Decrement 0000 01da, increment 0010 10da all flags; four skip variants no flags.
// - Carry rotates 0011 01da/00da: C, Z, N; plain rotates 0100: Z, N; swap none.
// - Prefix 0101: subtract 11da, with borrow 10da, reverse 01da; move 00da Z, N.
// - Multiply 0000 001a: one cycle, no status flags.
// - Fast bit 1 saves or restores shadow registers; 0 leaves them unused.
// - Multiply result lands in the product high and low byte pair.
package bopd_pkg;
	// Word layout
	localparam int WORD_W = 16;
	localparam int PFX_MSB = 15;
	localparam int PFX_LSB = 12;
	localparam int DEST_BIT = 9;
	localparam int ACCESS_BIT = 8;
	localparam int FAST_BIT = 8;
	localparam int BITPOS_LSB = 9;
	localparam int BITPOS_W = 3;
	localparam int FILE_W = 8;
	localparam int ADDR_W = 12;
	localparam int TARGET_W = 20;
	localparam int LONG_OFF_W = 11;
	localparam int SHORT_OFF_W = 8;
	localparam int OP_FIELD_MSB = 11;
	localparam int BANK_W = 4;
	// Opcode prefixes
	localparam logic [3:0] PFX_MISC = 4'h0;
	localparam logic [3:0] PFX_LOGIC = 4'h1;
	localparam logic [3:0] PFX_ADD = 4'h2;
	localparam logic [3:0] PFX_ROT = 4'h3;
	localparam logic [3:0] PFX_DSKIP = 4'h4;
	localparam logic [3:0] PFX_SUB = 4'h5;
	localparam logic [3:0] PFX_REG = 4'h6;
	localparam logic [3:0] PFX_MOVE = 4'hc;
	localparam logic [3:0] PFX_REL = 4'hd;
	localparam logic [3:0] PFX_CTRL = 4'he;
	localparam logic [3:0] PFX_SECOND = 4'hf;
	// Sub codes in bits 11:10, 11:9 and 11:8
	localparam logic [1:0] SUB2_0 = 2'h0;
	localparam logic [1:0] SUB2_1 = 2'h1;
	localparam logic [1:0] SUB2_2 = 2'h2;
	localparam logic [1:0] SUB2_3 = 2'h3;
	localparam logic [2:0] SUB3_MUL = 3'h1;
	localparam logic [2:0] SUB3_CALL = 3'h6;
	localparam logic [3:0] CTRL_GOTO = 4'hf;
	localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;
	// Flag mask bits {C, DC, Z, OV, N}
	localparam logic [4:0] FLAGS_NONE = 5'h00;
	localparam logic [4:0] FLAGS_ALL = 5'h1f;
	localparam logic [4:0] FLAGS_ZN = 5'h05;
	localparam logic [4:0] FLAGS_CZN = 5'h15;
	localparam logic [4:0] FLAGS_Z = 5'h04;
	// APB register byte offsets
	localparam logic [7:0] REG_BANK = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_TIMER = 8'h08;
	localparam logic [7:0] REG_PORT_LO = 8'h0c;
	localparam logic [7:0] REG_PORT_HI = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_COUNT = 8'h18;
	localparam int CTRL_PRESC_BIT = 0;
	localparam int STATUS_PEND_BIT = 8;
	localparam int STATUS_FLUSH_BIT = 9;
	localparam logic [ADDR_W-1:0] TIMER_ADDR_RST = 12'h000;
	localparam logic [ADDR_W-1:0] PORT_LO_RST = 12'h000;
	localparam logic [ADDR_W-1:0] PORT_HI_RST = 12'h000;
	// Decoded operations
	typedef enum logic [5:0] {
		OP_NOP, OP_ADD, OP_ADDC, OP_OR, OP_AND, OP_XOR, OP_COMP,
		OP_SET, OP_CLEAR, OP_NEGATE, OP_ACC_MOVE, OP_CMP_LT, OP_CMP_EQ, OP_CMP_GT,
		OP_TEST_ZERO, OP_DEC, OP_INC, OP_DEC_SZ, OP_DEC_SNZ, OP_INC_SZ, OP_INC_SNZ,
		OP_RL_C, OP_RR_C, OP_RL_PLAIN, OP_RR_PLAIN, OP_SWAP, OP_SUB, OP_SUB_B,
		OP_RSUB_B, OP_REG_MOVE, OP_MUL, OP_REG_REG_MOVE, OP_BRANCH_ALWAYS, OP_REL_CALL,
		OP_COND_BRANCH, OP_CALL, OP_GOTO, OP_OTHER
	} bopd_op_type;
endpackage

// >>> inc/bopd_fields_if.sv
// Field bundle between the decoder and its word splitter.
// Assumes the decoder drives the word and the splitter returns pure fields.
`timescale 1ns/1ps
interface bopd_fields_if;
	logic [15:0] word;
	logic [3:0] prefix;
	logic [1:0] sub2;
	logic [2:0] sub3;
	logic [3:0] sub4;
	logic destSel;
	logic accessSel;
	logic fastSel;
	logic [7:0] fileAddr;
	logic [2:0] bitPos;
	logic [7:0] literal;
	logic [11:0] addr12;
	logic [10:0] longOff;
	logic secondTag;
	modport splitter (input word, output prefix, sub2, sub3, sub4, destSel, accessSel,
		fastSel, fileAddr, bitPos, literal, addr12, longOff, secondTag);
	modport decoder (output word, input prefix, sub2, sub3, sub4, destSel, accessSel,
		fastSel, fileAddr, bitPos, literal, addr12, longOff, secondTag);
endinterface

// >>> design/bopd_field_split.sv
// Word splitter: cuts a program word into its operand fields.
// Assumes the word is stable for the cycle; purely combinational.
`timescale 1ns/1ps
module bopd_field_split (
	// Field bundle
	bopd_fields_if.splitter fld
);
	// Opcode and sub codes on top of the word
	assign fld.prefix = fld.word[bopd_pkg::PFX_MSB:bopd_pkg::PFX_LSB];
	assign fld.sub2 = fld.word[bopd_pkg::OP_FIELD_MSB:bopd_pkg::DEST_BIT+1];
	assign fld.sub3 = fld.word[bopd_pkg::OP_FIELD_MSB:bopd_pkg::DEST_BIT];
	assign fld.sub4 = fld.word[bopd_pkg::OP_FIELD_MSB:bopd_pkg::ACCESS_BIT];
	// Select bits
	assign fld.destSel = fld.word[bopd_pkg::DEST_BIT];
	assign fld.accessSel = fld.word[bopd_pkg::ACCESS_BIT];
	assign fld.fastSel = fld.word[bopd_pkg::FAST_BIT];
	// Operand fields
	assign fld.fileAddr = fld.word[bopd_pkg::FILE_W-1:0];
	assign fld.bitPos = fld.word[bopd_pkg::BITPOS_LSB+bopd_pkg::BITPOS_W-1:bopd_pkg::BITPOS_LSB];
	assign fld.literal = fld.word[bopd_pkg::SHORT_OFF_W-1:0];
	assign fld.addr12 = fld.word[bopd_pkg::ADDR_W-1:0];
	assign fld.longOff = fld.word[bopd_pkg::LONG_OFF_W-1:0];
	assign fld.secondTag = (fld.word[bopd_pkg::PFX_MSB:bopd_pkg::PFX_LSB] == bopd_pkg::PFX_SECOND);
endmodule // bopd_field_split

// >>> tb/bopd_decoder_monitor.sv
// Checker on the decoder ports: fetch latency, decode, pairing, flush, APB answer.
// Assumes it is bound to bopd_decoder and sees its top ports only.
`timescale 1ns/1ps
module bopd_decoder_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB handshake
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// Fetch path and feedback
	input wire logic [15:0] fetchWord,
	input wire logic fetchValid,
	input wire logic testTrue,
	// Decoded controls
	input wire bopd_pkg::bopd_op_type opCode,
	input wire logic opValid,
	input wire logic execNop,
	input wire logic accWrite,
	input wire logic [11:0] regAddr,
	input wire logic [4:0] flagMask,
	input wire logic condOp,
	input wire logic pcChange,
	input wire logic [19:0] target,
	input wire logic targetValid,
	input wire logic shadowSave,
	input wire logic productWrite
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Word taken with no flush pending from the shown one
	wire clean = fetchValid && !pcChange && !(condOp && testTrue);
	sequence callWords;
		clean && fetchWord[15:9] == 7'h76 ##1 fetchValid && fetchWord[15:12] == 4'hf;
	endsequence
	sequence firstAccess;
		psel && penable && !pready;
	endsequence
	AST_LATENCY: assert property (opValid == $past(fetchValid))
		else $error("opValid does not follow fetchValid");
	AST_ADD: assert property (clean && fetchWord[15:10] == 6'h09 |=>
		opCode == bopd_pkg::OP_ADD && flagMask == 5'h1f) else $error("add decode wrong");
	AST_DEST: assert property (clean && fetchWord[15:12] == 4'h1 |=>
		accWrite == !$past(fetchWord[9])) else $error("destination select wrong");
	AST_ACCESS_BANK: assert property (clean && fetchWord[15:13] == 3'h1 && !fetchWord[8] |=>
		regAddr == {4'h0, $past(fetchWord[7:0])}) else $error("access bank wrong");
	AST_CALL: assert property (callWords |=> targetValid && execNop &&
		target == {$past(fetchWord[11:0]), $past(fetchWord[7:0], 2)} &&
		shadowSave == $past(fetchWord[8], 2)) else $error("call target wrong");
	AST_FLUSH: assert property ((pcChange || condOp && testTrue) && fetchValid |=>
		execNop && opCode == bopd_pkg::OP_NOP) else $error("flushed word not nop");
	AST_MUL: assert property (clean && fetchWord[15:9] == 7'h01 |=>
		productWrite && flagMask == 5'h00) else $error("multiply decode wrong");
	AST_APB: assert property (firstAccess |=> pready ##1 !pready)
		else $error("pready not a one-cycle answer");
endmodule // bopd_decoder_monitor
////////////////////////////////////////////////////////////////////////////////
bind bopd_decoder bopd_decoder_monitor mon (.*);

// >>> tb/bopd_decoder_bench.sv
// Self-checking bench for the decoder: APB register access and fetch streams.
// Assumes the monitor is bound to the design and a 4 ns clock.
`timescale 1ns/1ps
module bopd_decoder_bench;
	// Stimulus and observed ports
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fetchValid = 0, testTrue = 0;
	logic [7:0] paddr = 8'h00;
	logic [15:0] fetchWord = 16'h0000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, opValid, execNop, accWrite, regWrite, condOp, pcChange, err;
	logic moveValid, targetValid, shadowSave, productWrite, readPins, prescalerClear;
	logic [11:0] regAddr, moveSrc, moveDst;
	logic [4:0] flagMask;
	logic [19:0] target;
	logic [2:0] bitPos;
	logic [7:0] literal, shortOffset;
	logic [10:0] longOffset;
	bopd_pkg::bopd_op_type opCode;
	int failures = 0, testsRun = 0, cycles = 0;
	// Byte-op top bytes in enum order, with their flag masks
	logic [7:0] codes [30] = '{8'h24, 8'h20, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h68, 8'h6a, 8'h6c,
		8'h6e, 8'h60, 8'h62, 8'h64, 8'h66, 8'h04, 8'h28, 8'h2c, 8'h4c, 8'h3c, 8'h48, 8'h34,
		8'h30, 8'h44, 8'h40, 8'h38, 8'h5c, 8'h58, 8'h54, 8'h50, 8'h02};
	logic [4:0] masks [30] = '{5'h1f, 5'h1f, 5'h05, 5'h05, 5'h05, 5'h05, 5'h00, 5'h04, 5'h1f,
		5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h1f, 5'h1f, 5'h00, 5'h00, 5'h00, 5'h00, 5'h15,
		5'h15, 5'h05, 5'h05, 5'h00, 5'h1f, 5'h1f, 5'h1f, 5'h05, 5'h00};
	bopd_decoder dut (.*);
	always #2 clk = ~clk;
	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			failures++;
			complete_run();
		end
	end
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer; read data and error land in rd and err
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Present a word; returns with the previous word's decode settled
	task automatic feed(input logic [15:0] w, input logic v);
		@(posedge clk);
		fetchWord <= w;
		fetchValid <= v;
		#1;
	endtask
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", testsRun, failures);
		if (failures == 0 && testsRun > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// Register access, read-only and unmapped places
		apb(1'b0, bopd_pkg::REG_STATUS, 32'h0);
		check("status", 32'h0, rd);
		apb(1'b1, bopd_pkg::REG_BANK, 32'h5);
		apb(1'b0, bopd_pkg::REG_BANK, 32'h0);
		check("bank", 32'h5, rd);
		apb(1'b1, bopd_pkg::REG_STATUS, 32'h3ff);
		apb(1'b0, bopd_pkg::REG_STATUS, 32'h0);
		check("status ro", 32'h0, rd);
		apb(1'b0, 8'h1c, 32'h0);
		check("slverr", 32'h1, err);
		apb(1'b1, bopd_pkg::REG_TIMER, 32'h512);
		apb(1'b1, bopd_pkg::REG_CTRL, 32'h1);
		apb(1'b1, bopd_pkg::REG_PORT_LO, 32'h520);
		apb(1'b1, bopd_pkg::REG_PORT_HI, 32'h52f);
		// Every byte-oriented encoding
		for (int i = 0; i < 30; i++) begin
			feed({codes[i], 8'h12}, 1'b1);
			feed(16'h0000, 1'b0);
			check("opcode", bopd_pkg::bopd_op_type'(i + 1), opCode);
			check("flags", masks[i], flagMask);
			check("product", i == 29, productWrite);
			check("address", 12'h012, regAddr);
		end
		// Banked operands, timer and port side effects
		feed(16'h2712, 1'b1);
		feed(16'h2720, 1'b1);
		check("bank1", 12'h512, regAddr);
		check("presc", 32'h1, prescalerClear);
		feed(16'h2120, 1'b1);
		check("pins", 32'h1, readPins);
		check("regdest", 32'h1, regWrite);
		feed(16'hec05, 1'b1);
		check("pins acc", 32'h0, readPins);
		check("accdest", 32'h1, accWrite);
		// Two-word pairs, flushes and a lone second word
		feed(16'hf123, 1'b1);
		feed(16'h0000, 1'b1);
		check("target", 20'h12305, target);
		check("fast0", 32'h0, shadowSave);
		feed(16'hc0ab, 1'b1);
		check("flushed", 32'h1, execNop);
		feed(16'hff56, 1'b1);
		feed(16'hed07, 1'b1);
		check("movesrc", 12'h0ab, moveSrc);
		check("movedst", 12'hf56, moveDst);
		check("movevalid", 32'h1, moveValid);
		check("second nop", 32'h1, execNop);
		feed(16'hf0ab, 1'b1);
		feed(16'h0000, 1'b1);
		check("target fast", 20'h0ab07, target);
		check("fast1", 32'h1, shadowSave);
		feed(16'hfabc, 1'b1);
		feed(16'h6212, 1'b1);
		check("lone", 32'h1, execNop);
		// True skip turns the next word into a nop
		@(posedge clk);
		fetchWord <= 16'h2612;
		testTrue <= 1'b1;
		@(posedge clk);
		fetchValid <= 1'b0;
		testTrue <= 1'b0;
		#1;
		check("skip", 32'h1, execNop);
		// Raw operand fields of bit, branch and conditional words
		feed(16'h9b5a, 1'b1);
		feed(16'hd5a7, 1'b1);
		check("bitpos", 32'h5, bitPos);
		check("literal", 32'h5a, literal);
		check("bit acc", 32'h0, accWrite);
		feed(16'he0c3, 1'b1);
		check("longoff", 32'h5a7, longOffset);
		check("branch pc", 32'h1, pcChange);
		feed(16'he0c3, 1'b1);
		check("bra flush", 32'h1, execNop);
		feed(16'h0000, 1'b0);
		check("shortoff", 32'hc3, shortOffset);
		check("cond", 32'h1, condOp);
		complete_run();
	end
endmodule // bopd_decoder_bench
